/* File: verilog/tbu_pkg.sv */
// Package with the register map, field layout and modes of the time base
package tbu_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL = 6'h00;
  localparam logic [5:0] IDX_PHASE   = 6'h06;
  localparam logic [5:0] IDX_COUNT   = 6'h08;
  localparam logic [5:0] IDX_PERIOD  = 6'h0A;
  // Control field positions
  localparam int EMU_HI     = 15;
  localparam int EMU_LO     = 14;
  localparam int PHDIR_POS  = 13;
  localparam int PRE_HI     = 12;
  localparam int PRE_LO     = 10;
  localparam int HSPRE_HI   = 9;
  localparam int HSPRE_LO   = 7;
  localparam int PHEN_POS   = 2;
  localparam int MODE_HI    = 1;
  localparam int MODE_LO    = 0;
  // Reset values
  localparam logic [15:0] CONTROL_RST = 16'h0083;
  localparam logic [15:0] PHASE_RST   = 16'h0000;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] PERIOD_RST  = 16'h0000;
  // Emulation halt codes
  localparam logic [1:0] EMU_STEP  = 2'h0;
  localparam logic [1:0] EMU_CYCLE = 2'h1;
  // Counter modes
  typedef enum logic [1:0] {
    TBU_UP, TBU_DOWN, TBU_UPDOWN, TBU_STOP
  } tbu_mode_t;
endpackage

/* File: verilog/tbu_ps_if.sv */
// Interface between the time base and its prescaler
`timescale 1ns/1ps
interface tbu_ps_if;
  logic [2:0] pre_code;
  logic [2:0] hs_code;
  logic       tick;
  modport base (output pre_code, output hs_code, input tick);
  modport presc (input pre_code, input hs_code, output tick);
endinterface // tbu_ps_if

/* File: verilog/tbu_prescale.sv */
// Prescaler that makes the one-cycle counter tick
`timescale 1ns/1ps
module tbu_prescale
  import tbu_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  // Codes in, tick out
  tbu_ps_if.presc   ps
);
  logic [10:0] cnt;
  logic [10:0] next_cnt;
  logic        tick;
  logic        next_tick;
  logic [7:0]  pre_div;
  logic [3:0]  hs_div;
  logic [10:0] total;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    pre_div = 8'h01 << ps.pre_code;
    hs_div = (ps.hs_code == 3'h0) ? 4'h1 : {ps.hs_code, 1'b0};
    total = 11'(pre_div) * 11'(hs_div);
    next_tick = 1'b0;
    next_cnt = cnt + 11'h001;
    if (cnt >= total - 11'h001) begin
      next_cnt = 11'h000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt  <= 11'h000;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

  assign ps.tick = tick;

  ////////////////////////////////////////////////////////////////////////////
  property p_tick_width;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (tick && total > 11'h001 && $stable(total)) |=> !tick;
  endproperty
  a_tick_width: assert property (p_tick_width)
    else $error("tick longer than one cycle");

  property p_div_two;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (tick && total == 11'h002 && $stable(total))
      |=> !tick ##1 (tick || $past(total) != 11'h002);
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("divide by two spacing wrong");

  property p_hs_code;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      ps.hs_code == 3'h7 |-> hs_div == 4'hE;
  endproperty
  a_hs_code: assert property (p_hs_code)
    else $error("high speed code 7 not divide by 14");

  property p_pre_code;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      ps.pre_code == 3'h7 |-> pre_div == 8'h80;
  endproperty
  a_pre_code: assert property (p_pre_code)
    else $error("prescale code 7 not divide by 128");
endmodule // tbu_prescale

/* File: verilog/tbu_timebase.sv */
// Time-base counter with halt control, phase direction and APB registers
// What this block does
// - Halt code 0: freeze after the next single count step.
// - Halt code 1, up mode: run until count equals period, then freeze.
// - Halt code 1, down or up-down: run until count is zero, freeze.
// - Halt codes 2 and 3: ignore halt, counter runs freely.
// - Phase direction bit matters only in up-down mode.
// - Up-down: after a phase load, direction comes from the bit.
// - Bit 0 counts down after sync, bit 1 counts up.
// - Prescale codes 0..7 divide by 1..128; reset code 0.
// - Tick rate is clock over product of both divides.
// - High speed code 0 divides by 1, else twice code; reset 1.
`timescale 1ns/1ps
module tbu_timebase
  import tbu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Debug and sync
  input  wire logic        emu_halt_i,
  input  wire logic        sync_in_i,
  // Status
  output logic      [15:0] timebase_count_o,
  output logic             count_up_o,
  output logic             frozen_o
);
  logic [15:0] time_base_control, next_control;
  logic [15:0] phase_value, next_phase;
  logic [15:0] period_value, next_period;
  logic [15:0] count, next_count;
  logic        dir_up, next_dir_up;
  logic        step_done, next_step_done;
  logic        frozen, next_frozen;
  logic [31:0] prdata, next_prdata;
  logic        pready, next_pready;
  logic        pslverr, next_pslverr;
  logic        sync_m, sync_s, sync_d;
  logic        sync_evt;
  logic        freeze;
  logic        advance;
  logic        wr_en;
  logic        mapped;
  logic [1:0]  emu_code;
  tbu_mode_t   mode;
  logic [5:0]  idx;
  tbu_ps_if    ps ();

  assign emu_code = time_base_control[EMU_HI:EMU_LO];
  assign mode     = tbu_mode_t'(time_base_control[MODE_HI:MODE_LO]);
  assign idx      = paddr_i[7:2];
  assign ps.pre_code = time_base_control[PRE_HI:PRE_LO];
  assign ps.hs_code  = time_base_control[HSPRE_HI:HSPRE_LO];

  tbu_prescale u_prescale (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .ps        (ps)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sync pin through two flops, then rising edge
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_m <= 1'b0;
      sync_s <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      sync_m <= sync_in_i;
      sync_s <= sync_m;
      sync_d <= sync_s;
    end
  end
  assign sync_evt = sync_s & ~sync_d & time_base_control[PHEN_POS];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode and answer
  always_comb begin
    mapped = (paddr_i[1:0] == 2'b00) &&
             (idx == IDX_CONTROL || idx == IDX_PHASE ||
              idx == IDX_COUNT || idx == IDX_PERIOD);
    wr_en = psel_i & penable_i & pready & pwrite_i & mapped;
    next_pready  = psel_i & penable_i & ~pready;
    next_pslverr = psel_i & penable_i & ~pready & ~mapped;
    next_prdata  = prdata;
    if (psel_i && penable_i && !pready) begin
      next_prdata = 32'h0000_0000;
      if (!pwrite_i && mapped) begin
        case (idx)
          IDX_CONTROL: next_prdata = {16'h0000, time_base_control};
          IDX_PHASE:   next_prdata = {16'h0000, phase_value};
          IDX_COUNT:   next_prdata = {16'h0000, count};
          IDX_PERIOD:  next_prdata = {16'h0000, period_value};
          default:     next_prdata = 32'h0000_0000;
        endcase
      end
    end
    next_control = time_base_control;
    next_phase   = phase_value;
    next_period  = period_value;
    if (wr_en && idx == IDX_CONTROL) begin
      next_control = pwdata_i[15:0];
    end
    if (wr_en && idx == IDX_PHASE) begin
      next_phase = pwdata_i[15:0];
    end
    if (wr_en && idx == IDX_PERIOD) begin
      next_period = pwdata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, direction and halt
  always_comb begin
    freeze = 1'b0;
    if (emu_halt_i) begin
      case (emu_code)
        EMU_STEP:  freeze = step_done;
        EMU_CYCLE: freeze = (mode == TBU_UP) ? (count == period_value)
                                             : (count == 16'h0000);
        default:   freeze = 1'b0;
      endcase
    end
    // A granted halt or stop mode stops the count
    advance = ps.tick & ~freeze & (mode != TBU_STOP);
    next_step_done = emu_halt_i & (emu_code == EMU_STEP)
                     & (step_done | advance);
    next_frozen = freeze;
    next_count  = count;
    next_dir_up = dir_up;
    if (advance) begin
      case (mode)
        TBU_UP: begin
          next_dir_up = 1'b1;
          next_count = (count >= period_value) ? 16'h0000
                                               : count + 16'h0001;
        end
        TBU_DOWN: begin
          next_dir_up = 1'b0;
          next_count = (count == 16'h0000) ? period_value
                                           : count - 16'h0001;
        end
        TBU_UPDOWN: begin
          if (dir_up) begin
            if (count >= period_value) begin
              next_dir_up = 1'b0;
              next_count = count - 16'h0001;
            end else begin
              next_count = count + 16'h0001;
            end
          end else begin
            if (count == 16'h0000) begin
              next_dir_up = 1'b1;
              next_count = count + 16'h0001;
            end else begin
              next_count = count - 16'h0001;
            end
          end
        end
        default: next_count = count;
      endcase
    end
    if (sync_evt) begin
      next_count = phase_value;
      if (mode == TBU_UPDOWN) begin
        next_dir_up = time_base_control[PHDIR_POS];
      end
    end
    if (wr_en && idx == IDX_COUNT) begin
      next_count = pwdata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      time_base_control <= CONTROL_RST;
      phase_value       <= PHASE_RST;
      period_value      <= PERIOD_RST;
      count             <= COUNT_RST;
      dir_up            <= 1'b1;
      step_done         <= 1'b0;
      frozen            <= 1'b0;
      prdata            <= 32'h0000_0000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
    end else begin
      time_base_control <= next_control;
      phase_value       <= next_phase;
      period_value      <= next_period;
      count             <= next_count;
      dir_up            <= next_dir_up;
      step_done         <= next_step_done;
      frozen            <= next_frozen;
      prdata            <= next_prdata;
      pready            <= next_pready;
      pslverr           <= next_pslverr;
    end
  end

  assign prdata_o         = prdata;
  assign pready_o         = pready;
  assign pslverr_o        = pslverr;
  assign timebase_count_o = count;
  assign count_up_o       = dir_up;
  assign frozen_o         = frozen;

  ////////////////////////////////////////////////////////////////////////////
  property p_halt_step;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (emu_halt_i && emu_code == EMU_STEP && advance && !sync_evt)[*1]
      ##1 (emu_halt_i && emu_code == EMU_STEP) |-> freeze;
  endproperty
  a_halt_step: assert property (p_halt_step)
    else $error("step halt did not freeze after one step");

  property p_cycle_up;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (frozen && $past(emu_code) == EMU_CYCLE && $past(mode) == TBU_UP)
      |-> $past(count) == $past(period_value);
  endproperty
  a_cycle_up: assert property (p_cycle_up)
    else $error("up mode froze away from period");

  property p_cycle_down;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (frozen && $past(emu_code) == EMU_CYCLE && $past(mode) != TBU_UP)
      |-> $past(count) == 16'h0000;
  endproperty
  a_cycle_down: assert property (p_cycle_down)
    else $error("down mode froze away from zero");

  property p_free;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      emu_code[1] |=> !frozen || !$past(emu_code[1]);
  endproperty
  a_free: assert property (p_free)
    else $error("free run code froze the counter");

  property p_up_ignores_dir;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (mode == TBU_UP && advance && !sync_evt && !wr_en
       && count < period_value) |=> count == $past(count) + 16'h0001;
  endproperty
  a_up_ignores_dir: assert property (p_up_ignores_dir)
    else $error("up mode step was not an increment");

  property p_dir_ignored;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (sync_evt && (mode == TBU_UP || mode == TBU_DOWN))
      |=> dir_up == ($past(advance) ? ($past(mode) == TBU_UP)
                                    : $past(dir_up));
  endproperty
  a_dir_ignored: assert property (p_dir_ignored)
    else $error("direction bit used outside up-down mode");

  property p_phase_dir;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (sync_evt && mode == TBU_UPDOWN)
      |=> dir_up == $past(time_base_control[PHDIR_POS])
          && count == $past(phase_value) || $past(wr_en);
  endproperty
  a_phase_dir: assert property (p_phase_dir)
    else $error("phase load direction wrong");

  property p_dir_down;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      (sync_evt && mode == TBU_UPDOWN && !time_base_control[PHDIR_POS])
      ##1 (advance && !sync_evt && !wr_en && count != 16'h0000)
      |=> count == $past(count) - 16'h0001;
  endproperty
  a_dir_down: assert property (p_dir_down)
    else $error("counter did not count down after sync");

  property p_halt_cause;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      frozen |-> $past(emu_halt_i) && !$past(emu_code[1]);
  endproperty
  a_halt_cause: assert property (p_halt_cause)
    else $error("counter frozen without a permitted halt");
endmodule // tbu_timebase

/* File: test/tb_top.sv */
// Self-checking bench for the time-base block over its APB port
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
  end end
module tb_top;
  import tbu_pkg::*;
  logic        clk_sys_i;
  logic        rst_b_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        emu_halt_i;
  logic        sync_in_i;
  logic [15:0] timebase_count_o;
  logic        count_up_o;
  logic        frozen_o;
  logic [31:0] rd;
  logic        err;
  logic [15:0] c0;
  logic        dir;
  logic [1:0]  mode;
  logic        in_rng;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n, exp_n, p, h;

  tbu_timebase u_dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .emu_halt_i(emu_halt_i), .sync_in_i(sync_in_i),
    .timebase_count_o(timebase_count_o), .count_up_o(count_up_o),
    .frozen_o(frozen_o));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task complete_run;
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) @(posedge clk_sys_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  function logic [31:0] ctl(logic [1:0] e, logic dr, logic [2:0] pr,
                            logic [2:0] hs, logic ph, logic [1:0] m);
    return {16'h0000, e, dr, pr, hs, 4'h0, ph, m};
  endfunction

  // Cycles between two successive count steps
  task gap(output int k);
    logic [15:0] v;
    @(posedge clk_sys_i);
    v = timebase_count_o;
    while (timebase_count_o === v) @(posedge clk_sys_i);
    v = timebase_count_o;
    k = 0;
    while (timebase_count_o === v) begin
      @(posedge clk_sys_i);
      k++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    emu_halt_i = 1'b0;
    sync_in_i = 1'b0;
    rst_b_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    apb(1'b0, 8'h00, 32'h0000_0000);
    `CHK("control_reset", 32'h0000_0083, rd) // reset codes
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, err)
    apb(1'b1, 8'h28, 32'h0000_FFFF);
    for (int i = 0; i < 16; i++) begin
      p = (i < 8) ? i : ((i == 15) ? 7 : 0);
      h = (i < 8) ? 0 : ((i == 15) ? 7 : i - 7);
      exp_n = (1 << p) * ((h == 0) ? 1 : 2 * h);
      apb(1'b1, 8'h00, ctl(2'h0, 1'b0, p[2:0], h[2:0], 1'b0, 2'h0));
      gap(n);
      gap(n);
      `CHK("tick_gap", exp_n, n)
    end
    apb(1'b1, 8'h00, ctl(2'h0, 1'b0, 3'h3, 3'h0, 1'b0, 2'h0));
    @(posedge clk_sys_i);
    emu_halt_i <= 1'b1;
    @(negedge clk_sys_i);
    c0 = timebase_count_o;
    repeat (40) @(posedge clk_sys_i);
    `CHK("halt_step", c0 + 16'h0001, timebase_count_o) // one step
    `CHK("halt_frozen", 1'b1, frozen_o) // frozen flag
    for (int e = 2; e < 4; e++) begin
      apb(1'b1, 8'h00, ctl(e[1:0], 1'b0, 3'h3, 3'h0, 1'b0, 2'h0));
      c0 = timebase_count_o;
      repeat (20) @(posedge clk_sys_i);
      `CHK("free_run", 1'b1, timebase_count_o !== c0)
      `CHK("free_not_frozen", 1'b0, frozen_o) // no freeze
    end
    apb(1'b1, 8'h28, 32'h0000_0014);
    apb(1'b1, 8'h20, 32'h0000_0000);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 8'h00, ctl(2'h1, 1'b0, 3'h0, 3'h0, 1'b0, m[1:0]));
      repeat (100) @(posedge clk_sys_i);
      c0 = (m == 0) ? 16'h0014 : 16'h0000;
      `CHK("halt_cycle", c0, timebase_count_o)
    end
    @(posedge clk_sys_i);
    emu_halt_i <= 1'b0;
    apb(1'b1, 8'h18, 32'h0000_0032);
    apb(1'b1, 8'h28, 32'h0000_0064);
    for (int k = 0; k < 3; k++) begin
      dir = (k == 1);
      mode = (k == 2) ? 2'h0 : 2'h2;
      apb(1'b1, 8'h00, ctl(2'h2, dir, 3'h4, 3'h0, 1'b1, mode));
      repeat (4) @(posedge clk_sys_i);
      sync_in_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      sync_in_i <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      in_rng = (timebase_count_o >= 16'h0031) &&
               (timebase_count_o <= 16'h0033);
      `CHK("load_dir", (k != 0), count_up_o)
      `CHK("phase_load", 1'b1, in_rng)
    end
    complete_run();
  end
endmodule // tb_top
